// >>> async_serial_adapter_map.svh
// Purpose: Register map, field positions, reset values and counts
// Assumes: Included by bare name
// Notes: Definitions only
`ifndef ASYNC_SERIAL_ADAPTER_MAP_SVH
`define ASYNC_SERIAL_ADAPTER_MAP_SVH
// Register select codes
`define ADDR_DATA 2'h0
`define ADDR_STATUS 2'h1
`define ADDR_CMD 2'h2
`define ADDR_CTL 2'h3
// Status fields
`define ST_PARITY 0
`define ST_FRAMING 1
`define ST_OVERRUN 2
`define ST_RX_FULL 3
`define ST_TX_EMPTY 4
`define ST_CARRIER 5
`define ST_SET_READY 6
`define ST_IRQ 7
// Command fields
`define CMD_ENABLE 0
`define CMD_RX_IRQ_OFF 1
`define CMD_TX_LO 2
`define CMD_TX_HI 3
`define CMD_ECHO 4
`define CMD_PAR_EN 5
`define CMD_PAR_LO 6
`define CMD_PAR_HI 7
`define CMD_PROG_RESET_MASK 8'hE0
// Control fields
`define CTL_BAUD_HI 3
`define CTL_RX_INTERNAL 4
`define CTL_LEN_LO 5
`define CTL_LEN_HI 6
`define CTL_STOP 7
// Reset values
`define CMD_RESET 8'h00
`define CTL_RESET 8'h00
`define STATUS_RESET 8'h10
// Oversampling counts
`define OVS_LAST 6'h0F
`define OVS_MID 6'h07
`define STOP_ONE 6'h10
`define STOP_ONE_HALF 6'h18
`define STOP_TWO 6'h20
`endif

// >>> async_serial_adapter_pkg.sv
// Purpose: Shared types of the serial adapter
// Assumes: Constants live in the map header
// Notes: Types only
package async_serial_adapter_pkg;
  typedef enum logic {MODE_STROBE, MODE_SPLIT} bus_mode_t;
  typedef enum logic [2:0] {S_IDLE, S_START, S_DATA, S_PAR, S_STOP} frame_state_t;
  typedef struct packed {
    logic [1:0] len_code;
    logic par_en;
    logic [1:0] par_mode;
    logic stop_long;
  } frame_cfg_t;
endpackage : async_serial_adapter_pkg

// >>> serial_tx.sv
// Purpose: Serial transmitter, 16 ticks per bit
// Assumes: i_tick is a one-cycle 16x pulse
// Notes: Idle line is mark
`include "async_serial_adapter_map.svh"
`timescale 1ns/1ps
module serial_tx (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_tick,
  input wire logic i_enable,
  input wire async_serial_adapter_pkg::frame_cfg_t i_cfg,
  // Holding register side
  input wire logic i_valid,
  input wire logic [7:0] i_data,
  output logic o_take,
  // Line
  output logic o_txd
);
  async_serial_adapter_pkg::frame_state_t state_reg;
  logic [5:0] cnt_reg;
  logic [2:0] bit_reg;
  logic [7:0] sh_reg;
  logic par_reg;
  wire [3:0] nbits = 4'h8 - {2'h0, i_cfg.len_code};
  wire [7:0] mask = 8'hFF >> i_cfg.len_code;
  wire [7:0] data_m = i_data & mask;
  wire par_odd = ~(^data_m);
  wire par_bit = i_cfg.par_mode[1] ? ~i_cfg.par_mode[0] : (i_cfg.par_mode[0] ? ~par_odd : par_odd);
  wire len5 = (i_cfg.len_code == 2'h3);
  wire len8 = (i_cfg.len_code == 2'h0);
  wire [5:0] stop_last = !i_cfg.stop_long ? `STOP_ONE - 6'h1 :
    (len5 && !i_cfg.par_en) ? `STOP_ONE_HALF - 6'h1 :
    (len8 && i_cfg.par_en) ? `STOP_ONE - 6'h1 : `STOP_TWO - 6'h1;
  wire bit_end = i_tick && (cnt_reg == `OVS_LAST);
  wire start_now = (state_reg == async_serial_adapter_pkg::S_IDLE) && i_tick && i_valid;

  assign o_take = start_now && i_enable;

  always_ff @(posedge i_clk) begin
    if (i_rst || !i_enable) begin
      state_reg <= async_serial_adapter_pkg::S_IDLE;
      o_txd <= 1'b1;
      cnt_reg <= 6'h00;
      bit_reg <= 3'h0;
      sh_reg <= 8'h00;
      par_reg <= 1'b0;
    end else begin
      if (i_tick) begin
        cnt_reg <= cnt_reg + 6'h01;
      end
      unique case (state_reg)
        async_serial_adapter_pkg::S_IDLE: begin
          cnt_reg <= 6'h00;
          if (start_now) begin
            state_reg <= async_serial_adapter_pkg::S_START;
            sh_reg <= data_m;
            par_reg <= par_bit;
            o_txd <= 1'b0;
          end
        end
        async_serial_adapter_pkg::S_START: begin
          if (bit_end) begin
            state_reg <= async_serial_adapter_pkg::S_DATA;
            cnt_reg <= 6'h00;
            bit_reg <= 3'h0;
            o_txd <= sh_reg[0];
            sh_reg <= sh_reg >> 1;
          end
        end
        async_serial_adapter_pkg::S_DATA: begin
          if (bit_end) begin
            cnt_reg <= 6'h00;
            bit_reg <= bit_reg + 3'h1;
            if ({1'b0, bit_reg} == nbits - 4'h1) begin
              state_reg <= i_cfg.par_en ? async_serial_adapter_pkg::S_PAR : async_serial_adapter_pkg::S_STOP;
              o_txd <= i_cfg.par_en ? par_reg : 1'b1;
            end else begin
              o_txd <= sh_reg[0];
              sh_reg <= sh_reg >> 1;
            end
          end
        end
        async_serial_adapter_pkg::S_PAR: begin
          if (bit_end) begin
            state_reg <= async_serial_adapter_pkg::S_STOP;
            cnt_reg <= 6'h00;
            o_txd <= 1'b1;
          end
        end
        async_serial_adapter_pkg::S_STOP: begin
          if (i_tick && cnt_reg == stop_last) begin
            state_reg <= async_serial_adapter_pkg::S_IDLE;
          end
        end
        default: state_reg <= async_serial_adapter_pkg::S_IDLE;
      endcase
    end
  end
endmodule : serial_tx

// >>> serial_rx.sv
// Purpose: Serial receiver, 16x oversampled
// Assumes: i_tick is a one-cycle 16x pulse
// Notes: Word handed over at mid stop bit
`include "async_serial_adapter_map.svh"
`timescale 1ns/1ps
module serial_rx (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Control
  input wire logic i_tick,
  input wire logic i_enable,
  input wire async_serial_adapter_pkg::frame_cfg_t i_cfg,
  // Line
  input wire logic i_rxd,
  // Received word
  output logic o_done,
  output logic [7:0] o_data,
  output logic o_frame_err,
  output logic o_par_err
);
  async_serial_adapter_pkg::frame_state_t state_reg;
  logic [5:0] cnt_reg;
  logic [2:0] bit_reg;
  logic [7:0] sh_reg;
  logic par_err_reg;
  wire [3:0] nbits = 4'h8 - {2'h0, i_cfg.len_code};
  wire [7:0] aligned = sh_reg >> i_cfg.len_code;
  wire par_ok = i_cfg.par_mode[0] ? ~(^{aligned, i_rxd}) : (^{aligned, i_rxd});
  wire mid = i_tick && (cnt_reg == `OVS_LAST);

  always_ff @(posedge i_clk) begin
    o_done <= 1'b0;
    if (i_rst || !i_enable) begin
      state_reg <= async_serial_adapter_pkg::S_IDLE;
      cnt_reg <= 6'h00;
      bit_reg <= 3'h0;
      sh_reg <= 8'h00;
      par_err_reg <= 1'b0;
      o_data <= 8'h00;
      o_frame_err <= 1'b0;
      o_par_err <= 1'b0;
    end else begin
      if (i_tick) begin
        cnt_reg <= cnt_reg + 6'h01;
      end
      unique case (state_reg)
        async_serial_adapter_pkg::S_IDLE: begin
          cnt_reg <= 6'h00;
          if (i_tick && !i_rxd) begin
            state_reg <= async_serial_adapter_pkg::S_START;
          end
        end
        async_serial_adapter_pkg::S_START: begin
          if (i_tick && cnt_reg == `OVS_MID) begin
            cnt_reg <= 6'h00;
            bit_reg <= 3'h0;
            par_err_reg <= 1'b0;
            state_reg <= i_rxd ? async_serial_adapter_pkg::S_IDLE : async_serial_adapter_pkg::S_DATA;
          end
        end
        async_serial_adapter_pkg::S_DATA: begin
          if (mid) begin
            cnt_reg <= 6'h00;
            sh_reg <= {i_rxd, sh_reg[7:1]};
            bit_reg <= bit_reg + 3'h1;
            if ({1'b0, bit_reg} == nbits - 4'h1) begin
              state_reg <= i_cfg.par_en ? async_serial_adapter_pkg::S_PAR : async_serial_adapter_pkg::S_STOP;
            end
          end
        end
        async_serial_adapter_pkg::S_PAR: begin
          if (mid) begin
            cnt_reg <= 6'h00;
            par_err_reg <= !i_cfg.par_mode[1] && !par_ok;
            state_reg <= async_serial_adapter_pkg::S_STOP;
          end
        end
        async_serial_adapter_pkg::S_STOP: begin
          if (mid) begin
            state_reg <= async_serial_adapter_pkg::S_IDLE;
            o_done <= 1'b1;
            o_data <= aligned;
            o_frame_err <= !i_rxd;
            o_par_err <= par_err_reg;
          end
        end
        default: state_reg <= async_serial_adapter_pkg::S_IDLE;
      endcase
    end
  end
endmodule : serial_rx

// >>> async_serial_adapter.sv
// Purpose: Asynchronous serial adapter on a multiplexed address/data bus
// Assumes: All pins synchronous to i_clk; bus strobes last several clocks
// Notes: Bus style detected from data_strobe at address strobe fall
`include "async_serial_adapter_map.svh"
`timescale 1ns/1ps
module async_serial_adapter #(
  parameter int BAUD_UNIT_DIV = 41
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_power_on_clear_n,
  // Processor bus
  input wire logic i_addr_latch_strobe,
  input wire logic i_data_strobe,
  input wire logic i_direction_line,
  input wire logic i_select_hi,
  input wire logic i_select_lo_n,
  input wire logic i_chip_enable_in,
  input wire logic [7:0] i_data,
  output logic [7:0] o_data,
  output logic o_data_oe_n,
  // Interrupt request, open drain
  output logic o_irq_n,
  output logic o_irq_oe_n,
  // Clock pins
  input wire logic i_osc_in,
  output logic o_osc_out,
  input wire logic i_rx_sixteen_clock,
  output logic o_rx_sixteen_clock,
  output logic o_rx_sixteen_clock_oe_n,
  // Modem lines
  output logic o_txd,
  input wire logic i_rxd,
  output logic o_rts_n,
  input wire logic i_cts_n,
  output logic o_dtr_n,
  input wire logic i_dcd_n,
  input wire logic i_dsr_n
);
  initial begin
    if (BAUD_UNIT_DIV < 2 || BAUD_UNIT_DIV * 16 > 65535) begin
      $error("BAUD_UNIT_DIV out of range");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus sampling and decode
  wire rst = i_sys_rst || !i_power_on_clear_n;
  logic as_reg, ds_reg, dir_reg, sel_reg;
  logic [7:0] din_reg;
  logic [1:0] addr_reg;
  async_serial_adapter_pkg::bus_mode_t mode_reg;
  logic rd_act_reg, wr_act_reg;
  logic [7:0] cmd_reg, ctl_reg, tx_hold_reg, rx_hold_reg;
  logic par_err_reg, frame_err_reg, overrun_reg, rx_full_reg, tx_empty_reg;
  logic dcd_reg, dsr_reg, frozen_reg, irq_reg;

  wire sel_now = i_select_hi && !i_select_lo_n && i_chip_enable_in;
  wire as_fall = as_reg && !i_addr_latch_strobe;
  wire split = (mode_reg == async_serial_adapter_pkg::MODE_SPLIT);
  wire rd_act = sel_now && (split ? !i_data_strobe : (i_data_strobe && i_direction_line));
  wire wr_act = sel_now && (split ? !i_direction_line : (i_data_strobe && !i_direction_line));
  wire rd_pulse = rd_act_reg && !rd_act;
  wire wr_pulse = wr_act_reg && !wr_act;
  wire rd_data = rd_pulse && addr_reg == `ADDR_DATA;
  wire rd_status = rd_pulse && addr_reg == `ADDR_STATUS;
  wire wr_data = wr_pulse && addr_reg == `ADDR_DATA;
  wire wr_preset = wr_pulse && addr_reg == `ADDR_STATUS;
  wire wr_cmd = wr_pulse && addr_reg == `ADDR_CMD;
  wire wr_ctl = wr_pulse && addr_reg == `ADDR_CTL;

  always_ff @(posedge i_clk) begin
    as_reg <= i_addr_latch_strobe;
    ds_reg <= i_data_strobe;
    dir_reg <= i_direction_line;
    sel_reg <= sel_now;
    din_reg <= i_data;
    if (rst) begin
      rd_act_reg <= 1'b0;
      wr_act_reg <= 1'b0;
      addr_reg <= 2'h0;
      mode_reg <= async_serial_adapter_pkg::MODE_STROBE;
    end else begin
      rd_act_reg <= rd_act;
      wr_act_reg <= wr_act;
      if (as_fall) begin
        addr_reg <= din_reg[1:0];
        mode_reg <= ds_reg ? async_serial_adapter_pkg::MODE_SPLIT : async_serial_adapter_pkg::MODE_STROBE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Command and control registers
  wire enabled = cmd_reg[`CMD_ENABLE];
  wire [1:0] tx_ctl = cmd_reg[`CMD_TX_HI:`CMD_TX_LO];
  async_serial_adapter_pkg::frame_cfg_t cfg;
  assign cfg.len_code = ctl_reg[`CTL_LEN_HI:`CTL_LEN_LO];
  assign cfg.par_en = cmd_reg[`CMD_PAR_EN];
  assign cfg.par_mode = cmd_reg[`CMD_PAR_HI:`CMD_PAR_LO];
  assign cfg.stop_long = ctl_reg[`CTL_STOP];

  always_ff @(posedge i_clk) begin
    if (rst) begin
      cmd_reg <= `CMD_RESET;
      ctl_reg <= `CTL_RESET;
    end else begin
      if (wr_cmd) begin
        cmd_reg <= din_reg;
      end else if (wr_preset) begin
        cmd_reg <= cmd_reg & `CMD_PROG_RESET_MASK;
      end
      if (wr_ctl) begin
        ctl_reg <= din_reg;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Baud generation and clock pins
  logic [15:0] div_reg;
  logic osc_reg, rxc_reg, tick_int_reg;
  wire [15:0] div_last = 16'(BAUD_UNIT_DIV * (16 - int'(ctl_reg[`CTL_BAUD_HI:0]))) - 16'h1;
  wire ext_baud = (ctl_reg[`CTL_BAUD_HI:0] == 4'h0);
  wire osc_rise = i_osc_in && !osc_reg;
  wire rxc_rise = i_rx_sixteen_clock && !rxc_reg;
  wire tx_tick = ext_baud ? osc_rise : tick_int_reg;
  wire rx_internal = ctl_reg[`CTL_RX_INTERNAL];
  wire rx_tick = rx_internal ? tx_tick : rxc_rise;

  always_ff @(posedge i_clk) begin
    osc_reg <= i_osc_in;
    rxc_reg <= i_rx_sixteen_clock;
    if (rst) begin
      div_reg <= 16'h0000;
      tick_int_reg <= 1'b0;
      o_osc_out <= 1'b0;
      o_rx_sixteen_clock <= 1'b0;
      o_rx_sixteen_clock_oe_n <= 1'b1;
    end else begin
      tick_int_reg <= (div_reg >= div_last);
      div_reg <= (div_reg >= div_last) ? 16'h0000 : div_reg + 16'h0001;
      o_osc_out <= !i_osc_in;
      o_rx_sixteen_clock <= ext_baud ? i_osc_in : (div_reg <= (div_last >> 1));
      o_rx_sixteen_clock_oe_n <= !rx_internal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter and receiver
  logic tx_take, rx_done, rx_ferr, rx_perr;
  logic [7:0] rx_word;

  serial_tx u_tx (
    .i_clk(i_clk),
    .i_rst(rst),
    .i_tick(tx_tick),
    .i_enable(enabled && !i_cts_n),
    .i_cfg(cfg),
    .i_valid(!tx_empty_reg && !wr_data),
    .i_data(tx_hold_reg),
    .o_take(tx_take),
    .o_txd(o_txd)
  );

  serial_rx u_rx (
    .i_clk(i_clk),
    .i_rst(rst),
    .i_tick(rx_tick),
    .i_enable(enabled),
    .i_cfg(cfg),
    .i_rxd(i_rxd),
    .o_done(rx_done),
    .o_data(rx_word),
    .o_frame_err(rx_ferr),
    .o_par_err(rx_perr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Data registers and receive status
  wire rx_room = !rx_full_reg || rd_data;
  wire rx_store = rx_done && rx_room;

  always_ff @(posedge i_clk) begin
    if (rst) begin
      tx_hold_reg <= 8'h00;
      rx_hold_reg <= 8'h00;
      rx_full_reg <= 1'b0;
      tx_empty_reg <= 1'b1;
      overrun_reg <= 1'b0;
      frame_err_reg <= 1'b0;
      par_err_reg <= 1'b0;
    end else begin
      if (wr_data) begin
        tx_hold_reg <= din_reg;
        tx_empty_reg <= 1'b0;
      end else if (tx_take) begin
        tx_empty_reg <= 1'b1;
      end
      if (rx_store) begin
        rx_hold_reg <= rx_word;
        rx_full_reg <= 1'b1;
        frame_err_reg <= rx_ferr;
        par_err_reg <= rx_perr;
      end else if (rd_data) begin
        rx_full_reg <= 1'b0;
      end
      if (rx_done && !rx_room) begin
        overrun_reg <= 1'b1;
      end else if (wr_preset) begin
        overrun_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Modem lines and interrupts
  wire modem_diff = (i_dcd_n != dcd_reg) || (i_dsr_n != dsr_reg);
  wire modem_evt = enabled && modem_diff && (!frozen_reg || rd_status);
  wire rx_irq = rx_store && enabled && !cmd_reg[`CMD_RX_IRQ_OFF];
  wire tx_irq = tx_take && enabled && (tx_ctl == 2'h1);
  wire irq_set = modem_evt || rx_irq || tx_irq;
  wire [7:0] status = {irq_reg, dsr_reg, dcd_reg, tx_empty_reg, rx_full_reg,
    overrun_reg, frame_err_reg, par_err_reg};

  always_ff @(posedge i_clk) begin
    if (rst) begin
      dcd_reg <= i_dcd_n;
      dsr_reg <= i_dsr_n;
      frozen_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      if (!enabled || !frozen_reg || rd_status) begin
        dcd_reg <= i_dcd_n;
        dsr_reg <= i_dsr_n;
      end
      if (modem_evt) begin
        frozen_reg <= 1'b1;
      end else if (rd_status || !enabled) begin
        frozen_reg <= 1'b0;
      end
      if (irq_set) begin
        irq_reg <= 1'b1;
      end else if (rd_status) begin
        irq_reg <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins
  wire [7:0] rd_mux = (addr_reg == `ADDR_DATA) ? rx_hold_reg :
    (addr_reg == `ADDR_STATUS) ? status :
    (addr_reg == `ADDR_CMD) ? cmd_reg : ctl_reg;

  always_ff @(posedge i_clk) begin
    if (rst) begin
      o_data <= 8'h00;
      o_data_oe_n <= 1'b1;
      o_irq_n <= 1'b0;
      o_irq_oe_n <= 1'b1;
      o_rts_n <= 1'b1;
      o_dtr_n <= 1'b1;
    end else begin
      o_data <= rd_mux;
      o_data_oe_n <= !rd_act;
      o_irq_n <= 1'b0;
      o_irq_oe_n <= !irq_reg;
      o_rts_n <= (tx_ctl == 2'h0) && !cmd_reg[`CMD_ECHO];
      o_dtr_n <= !enabled;
    end
  end
endmodule : async_serial_adapter

// >>> asa_checker.sv
// Purpose: Port assertions of the serial adapter
// Assumes: Strobes last several clocks
// Notes: Bus style is tracked from the pins
`timescale 1ns/1ps
module asa_checker (
  // Clock and resets
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_power_on_clear_n,
  // Bus
  input wire logic i_addr_latch_strobe,
  input wire logic i_data_strobe,
  input wire logic i_direction_line,
  input wire logic i_select_hi,
  input wire logic i_select_lo_n,
  input wire logic i_chip_enable_in,
  input wire logic o_data_oe_n,
  input wire logic o_irq_n,
  input wire logic o_irq_oe_n,
  // Serial and modem
  input wire logic o_rx_sixteen_clock,
  input wire logic o_rx_sixteen_clock_oe_n,
  input wire logic o_txd,
  input wire logic o_rts_n,
  input wire logic i_cts_n,
  input wire logic o_dtr_n,
  input wire logic i_dcd_n
);
  logic as_reg, ds_reg, split_reg, wr_reg;
  logic [2:0] wr_age_reg;
  wire rst = i_sys_rst || !i_power_on_clear_n;
  wire sel = i_select_hi && !i_select_lo_n && i_chip_enable_in;
  wire rd_en = sel && (split_reg ? !i_data_strobe : i_data_strobe && i_direction_line);
  wire wr_en = sel && (split_reg ? !i_direction_line : i_data_strobe && !i_direction_line);
  wire wr_end = wr_reg && !wr_en;
  always_ff @(posedge i_clk) begin
    as_reg <= i_addr_latch_strobe;
    ds_reg <= i_data_strobe;
    wr_reg <= wr_en;
    if (rst) split_reg <= 1'b0;
    else if (as_reg && !i_addr_latch_strobe) split_reg <= ds_reg;
    if (rst || wr_end) wr_age_reg <= 3'h0;
    else if (wr_age_reg != 3'h7) wr_age_reg <= wr_age_reg + 3'h1;
  end
  ////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (rst);
  sequence s_read; rd_en; endsequence
  sequence s_cts_hi; i_cts_n [*3]; endsequence
  property p_oe_on; s_read |=> !o_data_oe_n; endproperty
  property p_oe_off; !rd_en |=> o_data_oe_n; endproperty
  property p_irq_level; !o_irq_n; endproperty
  property p_modem_irq; ($changed(i_dcd_n) && !o_dtr_n) |-> ##[1:3] !o_irq_oe_n; endproperty
  property p_cts_mark; s_cts_hi |-> o_txd; endproperty
  property p_rxclk; !o_rx_sixteen_clock_oe_n |-> ##[1:64] $changed(o_rx_sixteen_clock); endproperty
  property p_dtr_idle; o_dtr_n [*2] |-> o_txd; endproperty
  property p_rts_write; $changed(o_rts_n) |-> wr_age_reg < 3'h4; endproperty
  property p_dtr_write; $changed(o_dtr_n) |-> wr_age_reg < 3'h4; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("bus not driven during read");
  a_oe_off: assert property (p_oe_off)
    else $error("bus driven outside read");
  a_irq_level: assert property (p_irq_level)
    else $error("request line level not low");
  a_modem_irq: assert property (p_modem_irq)
    else $error("no request after carrier change");
  a_cts_mark: assert property (p_cts_mark)
    else $error("line not mark while clear-to-send high");
  a_rxclk: assert property (p_rxclk)
    else $error("receive clock output not running");
  a_dtr_idle: assert property (p_dtr_idle)
    else $error("line active while disabled");
  a_rts_write: assert property (p_rts_write)
    else $error("request-to-send moved without a write");
  a_dtr_write: assert property (p_dtr_write)
    else $error("terminal-ready moved without a write");
endmodule : asa_checker
bind async_serial_adapter asa_checker u_asa_checker (.i_clk, .i_sys_rst, .i_power_on_clear_n,
  .i_addr_latch_strobe, .i_data_strobe, .i_direction_line, .i_select_hi, .i_select_lo_n, .i_chip_enable_in,
  .o_data_oe_n, .o_irq_n, .o_irq_oe_n, .o_rx_sixteen_clock, .o_rx_sixteen_clock_oe_n, .o_txd, .o_rts_n,
  .i_cts_n, .o_dtr_n, .i_dcd_n);

// >>> asa_modem_model.sv
// Purpose: Modem side of the serial lines
// Assumes: No parity, one stop bit
// Notes: Idle line is mark
`timescale 1ns/1ps
module asa_modem_model #(
  parameter int BIT_CLKS = 32,
  parameter int NBITS = 7
) (
  input wire logic i_clk,
  input wire logic i_txd,
  output logic o_rxd
);
  logic [7:0] got_q[$];
  initial o_rxd = 1'b1;
  // Frame onto the receive line, low bit first
  task automatic send(input logic [7:0] v);
    int i;
    o_rxd <= 1'b0;
    repeat (BIT_CLKS) @(posedge i_clk);
    for (i = 0; i < NBITS; i++) begin
      o_rxd <= v[i];
      repeat (BIT_CLKS) @(posedge i_clk);
    end
    o_rxd <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge i_clk);
  endtask : send
  // Mid-bit capture of transmitted frames
  always begin : capture
    logic [7:0] v;
    int i;
    @(negedge i_txd);
    v = 8'h00;
    repeat (BIT_CLKS / 2) @(posedge i_clk);
    for (i = 0; i < NBITS; i++) begin
      repeat (BIT_CLKS) @(posedge i_clk);
      v[i] = i_txd;
    end
    got_q.push_back(v);
    repeat (BIT_CLKS) @(posedge i_clk);
  end
endmodule : asa_modem_model

// >>> tb_top.sv
// Purpose: Self-checking bench of the serial adapter
// Assumes: Baud code 15 with divisor 2 gives 32 clocks a bit
// Notes: Bus cycles follow the hand-over walk
`timescale 1ns/1ps
module tb_top;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic pc_n = 1'b1, as = 1'b0, ds = 1'b0, dir = 1'b1, sel_hi = 1'b1;
  logic sel_lo_n = 1'b0, ce = 1'b1;
  logic [1:0] dsel = 2'h0;
  logic cts_n = 1'b0, dcd_n = 1'b1, dsr_n = 1'b1, mode = 1'b0, cur = 1'b0;
  logic [7:0] din = 8'h00, o_data;
  logic o_data_oe_n, o_irq_n, o_irq_oe_n, o_txd, rxd, o_rts_n, o_dtr_n, rx_sixteen_clock, rxc_oe_n, osc_out;
  logic [31:0] lfsr_reg = 32'h340BD143;
  logic [7:0] tx_q[$];
  int errors = 0, checks_done = 0, cmd_m = 0, ctl_m = 0;
  always #4 i_clk = ~i_clk;
  async_serial_adapter #(.BAUD_UNIT_DIV(2)) u_async_serial_adapter (
    .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_power_on_clear_n(pc_n),
    .i_addr_latch_strobe(as), .i_data_strobe(ds), .i_direction_line(dir),
    .i_select_hi(sel_hi), .i_select_lo_n(sel_lo_n), .i_chip_enable_in(ce),
    .i_data(din), .o_data(o_data), .o_data_oe_n(o_data_oe_n), .o_irq_n(o_irq_n), .o_irq_oe_n(o_irq_oe_n),
    .i_osc_in(1'b0), .o_osc_out(osc_out), .i_rx_sixteen_clock(1'b0), .o_rx_sixteen_clock(rx_sixteen_clock),
    .o_rx_sixteen_clock_oe_n(rxc_oe_n), .o_txd(o_txd), .i_rxd(rxd), .o_rts_n(o_rts_n),
    .i_cts_n(cts_n), .o_dtr_n(o_dtr_n), .i_dcd_n(dcd_n), .i_dsr_n(dsr_n));
  asa_modem_model #(.BIT_CLKS(32), .NBITS(7)) u_asa_modem_model (.i_clk(i_clk), .i_txd(o_txd), .o_rxd(rxd));
  ////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic complete_run;
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : complete_run
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask : chk8
  // One access; a style change is made with the chip deselected
  task automatic bus(input logic r, input logic [1:0] a, input logic [7:0] wd, input logic en,
                     output logic [7:0] q);
    @(posedge i_clk);
    as <= 1'b1;
    ds <= mode;
    dir <= 1'b1;
    din <= {6'h00, a};
    sel_hi <= (mode == cur);
    cur = mode;
    @(posedge i_clk);
    as <= 1'b0;
    repeat (2) @(posedge i_clk);
    din <= wd;
    sel_hi <= en || dsel != 2'h0;
    sel_lo_n <= !en && dsel == 2'h1;
    ce <= en || dsel != 2'h2;
    if (mode && r) ds <= 1'b0;
    else if (mode) dir <= 1'b0;
    else begin
      ds <= 1'b1;
      dir <= r;
    end
    repeat (2) @(posedge i_clk);
    #1 q = o_data;
    if (r) chk8({7'h00, o_data_oe_n}, {7'h00, !en});
    @(posedge i_clk);
    ds <= mode;
    dir <= 1'b1;
    sel_hi <= 1'b1;
    sel_lo_n <= 1'b0;
    ce <= 1'b1;
    repeat (2) @(posedge i_clk);
    #1;
  endtask : bus
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b0, a, d, 1'b1, q);
    if (a == 2'h0) tx_q.push_back(d & (8'hFF >> ctl_m[6:5]));
    if (a == 2'h1) cmd_m = cmd_m & 8'hE0;
    if (a == 2'h2) cmd_m = d;
    if (a == 2'h3) ctl_m = d;
  endtask : wr
  task automatic rdc(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b1, a, 8'h00, 1'b1, q);
    chk8(q, e);
  endtask : rdc
  ////////////////////////////////////////////////////////////
  initial begin
    int i;
    logic [7:0] q;
    repeat (8) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    #1 chk8({o_txd, o_rts_n, o_dtr_n, rxc_oe_n, o_data_oe_n, o_irq_oe_n, 2'h0}, 8'hFC);
    rdc(2'h1, 8'h70);
    rdc(2'h2, 8'h00);
    rdc(2'h3, 8'h00);
    wr(2'h3, 8'h3F);
    wr(2'h2, 8'h09);
    rdc(2'h3, ctl_m[7:0]);
    // Refused accesses, one select false at a time
    for (i = 0; i < 3; i++) begin
      dsel = i[1:0];
      bus(i == 1, 2'h2, 8'hFF, 1'b0, q);
    end
    dsel = 2'h0;
    rdc(2'h2, cmd_m[7:0]);
    chk8({o_rts_n, o_dtr_n, rxc_oe_n, osc_out, 4'h0}, 8'h10);
    // Held transmit while clear-to-send is high
    @(posedge i_clk);
    cts_n <= 1'b1;
    lfsr_reg = lfsr_next(lfsr_reg);
    wr(2'h0, lfsr_reg[7:0]);
    rdc(2'h1, 8'h60);
    repeat (400) @(posedge i_clk);
    chk8({7'h00, u_asa_modem_model.got_q.size() == 0}, 8'h01);
    cts_n <= 1'b0;
    lfsr_reg = lfsr_next(lfsr_reg);
    wr(2'h0, lfsr_reg[7:0]);
    for (i = 0; i < 2000 && u_asa_modem_model.got_q.size() < 2; i++) @(posedge i_clk);
    if (u_asa_modem_model.got_q.size() < 2) begin
      errors++;
      complete_run();
    end
    for (i = 0; i < 2; i++) chk8(u_asa_modem_model.got_q.pop_front(), tx_q.pop_front());
    rdc(2'h1, 8'h70);
    // Receive with interrupt
    lfsr_reg = lfsr_next(lfsr_reg);
    @(posedge i_clk);
    u_asa_modem_model.send(lfsr_reg[7:0]);
    #1 chk8({7'h00, o_irq_oe_n}, 8'h00);
    rdc(2'h1, 8'hF8);
    rdc(2'h0, lfsr_reg[7:0] & (8'hFF >> ctl_m[6:5]));
    rdc(2'h1, 8'h70);
    // Modem line changes and freezing
    @(posedge i_clk);
    dcd_n <= 1'b0;
    repeat (4) @(posedge i_clk);
    #1 chk8({7'h00, o_irq_oe_n}, 8'h00);
    @(posedge i_clk);
    dsr_n <= 1'b0;
    rdc(2'h1, 8'hD0);
    repeat (4) @(posedge i_clk);
    #1 chk8({7'h00, o_irq_oe_n}, 8'h00);
    rdc(2'h1, 8'h90);
    // Split strobe style, programmed reset
    mode = 1'b1;
    wr(2'h3, 8'h5F);
    rdc(2'h3, ctl_m[7:0]);
    wr(2'h1, 8'h00);
    rdc(2'h2, cmd_m[7:0]);
    rdc(2'h3, ctl_m[7:0]);
    chk8({o_rts_n, o_dtr_n, 6'h00}, 8'hC0);
    wr(2'h2, 8'h09);
    // Power-on clear
    @(posedge i_clk);
    pc_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    pc_n <= 1'b1;
    cmd_m = 0;
    ctl_m = 0;
    cur = 1'b1;
    mode = 1'b0;
    rdc(2'h2, cmd_m[7:0]);
    rdc(2'h3, ctl_m[7:0]);
    complete_run();
  end
endmodule : tb_top
